// File: adcfhp_map.vh
`ifndef ADCFHP_MAP_VH
`define ADCFHP_MAP_VH

// Bus and sample widths.
`define ADCFHP_BUS_W          10
`define ADCFHP_SAMPLE_W       12
`define ADCFHP_DEPTH          16
`define ADCFHP_ADDR_W         4
`define ADCFHP_COUNT_W        5

// Field positions in the second control word.
`define ADCFHP_THR_LO_BIT     2
`define ADCFHP_THR_HI_BIT     3
`define ADCFHP_PULSE_BIT      4
`define ADCFHP_POLARITY_BIT   5
`define ADCFHP_DIR_MODE_BIT   6

// Reset values of the two control words.
`define ADCFHP_CW0_RESET      10'h000
`define ADCFHP_CW1_RESET      10'h030

// Fill thresholds, in converted values, per channel count and code.
`define ADCFHP_TL_1CH_0       5'h01
`define ADCFHP_TL_1CH_1       5'h04
`define ADCFHP_TL_1CH_2       5'h08
`define ADCFHP_TL_1CH_3       5'h0E
`define ADCFHP_TL_2CH_0       5'h02
`define ADCFHP_TL_2CH_1       5'h04
`define ADCFHP_TL_2CH_2       5'h08
`define ADCFHP_TL_2CH_3       5'h0C
`define ADCFHP_TL_3CH_0       5'h03
`define ADCFHP_TL_3CH_1       5'h06
`define ADCFHP_TL_3CH_2       5'h09
`define ADCFHP_TL_3CH_3       5'h0C
`define ADCFHP_TL_4CH_0       5'h04
`define ADCFHP_TL_4CH_1       5'h08
`define ADCFHP_TL_4CH_2       5'h0C
`define ADCFHP_TL_RESERVED    5'h00

`endif

// File: adcfhp_fifo_mem.v
`timescale 1ns/100ps

`include "adcfhp_map.vh"

// Word store of the converter FIFO; read data always come from a register.
module adcfhp_fifo_mem (
    input  wire                          sys_clk,
    input  wire                          wr_en,
    input  wire [`ADCFHP_ADDR_W-1:0]     wr_addr,
    input  wire [`ADCFHP_SAMPLE_W-1:0]   wr_data,
    input  wire [`ADCFHP_ADDR_W-1:0]     rd_addr,
    output reg  [`ADCFHP_SAMPLE_W-1:0]   rd_data
);

    reg [`ADCFHP_SAMPLE_W-1:0] store [0:`ADCFHP_DEPTH-1];

    always @(posedge sys_clk) begin
        if (wr_en) begin
            store[wr_addr] <= wr_data;
        end
        rd_data <= store[rd_addr];
    end

endmodule // adcfhp_fifo_mem

// File: adcfhp_port.v
`timescale 1ns/100ps

`include "adcfhp_map.vh"

// Overview of operation
// - Bits 3:2 of control word one choose the fill threshold code.
// - One channel: codes map to 1, 4, 8, 14 stored values.
// - Two channels: codes map to 2, 4, 8, 12 stored values.
// - Three channels: codes map to 3, 6, 9, 12 stored values.
// - Four channels: codes map to 4, 8, 12; code 11 reserved.
// - Results enter the FIFO in fixed channel order; a pair is one channel.
// - Read strobe active when both selects and read valid, write inactive.
// - Each read access pops one word, unless the FIFO is empty, and enables the output drivers.
// - Write strobe from both selects and write, read inactive; latches a word.
// - The write input may act as a combined read/write direction input.
// - Bit 6 selects direction mode; read input ignored; high reads, low writes.
// - Bit 5 chooses polarity, bit 4 chooses pulse or level flag.
// - Flag goes active when the fill reaches the threshold; in continuous pulse mode at the next conversion clock rise.
// - Level flag clears on first read; rechecked after threshold-count reads.
// - In continuous pulse mode the flag lasts half a conversion clock period; if the threshold-count reads end first, it holds until the next pulse ends.
// - No new pulse until threshold-count values before it were read.
// - Control word one resets to pulse, active high, separate strobes, code 00.
module adcfhp_port (
    input  wire                          sys_clk,
    input  wire                          nrst,
    input  wire                          chip_select_low_active,
    input  wire                          chip_select_high_active,
    input  wire                          read_strobe_n,
    input  wire                          write_strobe_n,
    input  wire                          control_word_select,
    input  wire [`ADCFHP_BUS_W-1:0]      bus_data_in,
    output reg  [`ADCFHP_SAMPLE_W-1:0]   bus_data_out,
    output reg                           bus_data_oe_n,
    input  wire [1:0]                    active_channels,
    input  wire                          continuous_mode,
    input  wire                          sample_clock_in,
    input  wire                          sample_valid,
    input  wire [`ADCFHP_SAMPLE_W-1:0]   sample_data,
    output reg                           sample_ready,
    output reg                           internal_read_pulse,
    output reg                           internal_write_pulse,
    output reg  [`ADCFHP_BUS_W-1:0]      control_word_zero,
    output reg  [`ADCFHP_BUS_W-1:0]      control_word_one,
    output reg  [`ADCFHP_COUNT_W-1:0]    fifo_fill,
    output reg                           fill_ready_flag
);

    localparam ST_ARMED = 1'b0;
    localparam ST_DRAIN = 1'b1;

    // Threshold lookup, used for the live compare and for the latched count.
    function [`ADCFHP_COUNT_W-1:0] threshold_count_of;
        input [1:0] chans;
        input [1:0] code;
        begin
            case ({chans, code})
                4'h0: threshold_count_of = `ADCFHP_TL_1CH_0;
                4'h1: threshold_count_of = `ADCFHP_TL_1CH_1;
                4'h2: threshold_count_of = `ADCFHP_TL_1CH_2;
                4'h3: threshold_count_of = `ADCFHP_TL_1CH_3;
                4'h4: threshold_count_of = `ADCFHP_TL_2CH_0;
                4'h5: threshold_count_of = `ADCFHP_TL_2CH_1;
                4'h6: threshold_count_of = `ADCFHP_TL_2CH_2;
                4'h7: threshold_count_of = `ADCFHP_TL_2CH_3;
                4'h8: threshold_count_of = `ADCFHP_TL_3CH_0;
                4'h9: threshold_count_of = `ADCFHP_TL_3CH_1;
                4'hA: threshold_count_of = `ADCFHP_TL_3CH_2;
                4'hB: threshold_count_of = `ADCFHP_TL_3CH_3;
                4'hC: threshold_count_of = `ADCFHP_TL_4CH_0;
                4'hD: threshold_count_of = `ADCFHP_TL_4CH_1;
                4'hE: threshold_count_of = `ADCFHP_TL_4CH_2;
                default: threshold_count_of = `ADCFHP_TL_RESERVED;
            endcase
        end
    endfunction

    wire                          both_selected;
    wire                          dir_mode;
    wire                          read_active;
    wire                          write_active;
    wire                          read_start;
    wire                          write_start;
    reg                           read_prev;
    reg                           write_prev;

    assign both_selected = ~chip_select_low_active & chip_select_high_active;
    assign dir_mode = control_word_one[`ADCFHP_DIR_MODE_BIT];

    // read input not looked at in direction mode
    assign read_active = both_selected &
        (dir_mode ? write_strobe_n : (~read_strobe_n & write_strobe_n));

    assign write_active = both_selected &
        (dir_mode ? ~write_strobe_n : (~write_strobe_n & read_strobe_n));

    assign read_start  = read_active & ~read_prev;
    assign write_start = write_active & ~write_prev;

    // Two-entry buffer between the converter and the FIFO.
    reg  [`ADCFHP_SAMPLE_W-1:0]   skid_data [0:1];
    reg  [1:0]                    skid_count;
    reg                           skid_head;
    reg  [`ADCFHP_ADDR_W-1:0]     wr_ptr;
    reg  [`ADCFHP_ADDR_W-1:0]     rd_ptr;
    wire                          fifo_full;
    wire                          fifo_empty;
    wire                          skid_out_valid;
    wire                          fifo_push;
    wire                          fifo_pop;
    wire                          skid_push;
    wire [`ADCFHP_SAMPLE_W-1:0]   mem_rd_data;
    wire [1:0]                    next_skid_count;

    assign fifo_full      = (fifo_fill == `ADCFHP_DEPTH);
    assign fifo_empty     = (fifo_fill == {`ADCFHP_COUNT_W{1'b0}});
    assign skid_out_valid = (skid_count != 2'h0);
    assign skid_push      = sample_valid & sample_ready;
    // strict first-in first-out keeps channel order
    assign fifo_push      = skid_out_valid & ~fifo_full;
    assign fifo_pop       = read_start & ~fifo_empty;
    assign next_skid_count = skid_count + {1'b0, skid_push} - {1'b0, fifo_push};

    always @(posedge sys_clk) begin
        if (!nrst) begin
            skid_count   <= 2'h0;
            skid_head    <= 1'b0;
            sample_ready <= 1'b0;
        end else begin
            if (skid_push) begin
                skid_data[skid_head ^ skid_count[0]] <= sample_data;
            end
            if (fifo_push) begin
                skid_head <= ~skid_head;
            end
            skid_count   <= next_skid_count;
            // Ready drops while both entries hold words, so a full FIFO stalls the source.
            sample_ready <= (next_skid_count != 2'h2);
        end
    end

    adcfhp_fifo_mem u_mem (
        .sys_clk (sys_clk),
        .wr_en   (fifo_push),
        .wr_addr (wr_ptr),
        .wr_data (skid_data[skid_head]),
        .rd_addr (rd_ptr),
        .rd_data (mem_rd_data)
    );

    always @(posedge sys_clk) begin
        if (!nrst) begin
            wr_ptr    <= {`ADCFHP_ADDR_W{1'b0}};
            rd_ptr    <= {`ADCFHP_ADDR_W{1'b0}};
            fifo_fill <= {`ADCFHP_COUNT_W{1'b0}};
        end else begin
            if (fifo_push) begin
                wr_ptr <= wr_ptr + 4'h1;
            end
            if (fifo_pop) begin
                rd_ptr <= rd_ptr + 4'h1;
            end
            fifo_fill <= fifo_fill + {4'h0, fifo_push} - {4'h0, fifo_pop};
        end
    end

    // Host port: strobes, data drivers and control words.
    always @(posedge sys_clk) begin
        if (!nrst) begin
            read_prev            <= 1'b0;
            write_prev           <= 1'b0;
            internal_read_pulse  <= 1'b0;
            internal_write_pulse <= 1'b0;
            bus_data_oe_n        <= 1'b1;
            bus_data_out         <= {`ADCFHP_SAMPLE_W{1'b0}};
            control_word_zero    <= `ADCFHP_CW0_RESET;
            control_word_one     <= `ADCFHP_CW1_RESET;
        end else begin
            read_prev            <= read_active;
            write_prev           <= write_active;
            internal_read_pulse  <= read_active;
            internal_write_pulse <= write_active;
            // drivers enabled for the whole access
            bus_data_oe_n        <= ~read_active;
            // The head word is sampled at the access start; a word written in the
            // previous cycle is not yet visible, and an empty FIFO gives the stale word at rd_ptr.
            if (read_start) begin
                bus_data_out <= mem_rd_data;
            end
            // latch into the addressed control word
            if (write_start) begin
                if (control_word_select) begin
                    control_word_one <= bus_data_in;
                end else begin
                    control_word_zero <= bus_data_in;
                end
            end
        end
    end

    // Data-available flag.
    reg                           flag_state;
    reg                           flag_active;
    reg  [`ADCFHP_COUNT_W-1:0]    reads_left;
    reg                           sclk_prev;
    reg                           next_flag_state;
    reg                           next_flag_active;
    reg  [`ADCFHP_COUNT_W-1:0]    next_reads_left;
    wire [`ADCFHP_COUNT_W-1:0]    threshold_count;
    wire                          pulse_mode;
    wire                          active_high;
    wire                          sclk_rise;
    wire                          sclk_fall;
    wire                          reached;

    assign threshold_count = threshold_count_of(active_channels,
        {control_word_one[`ADCFHP_THR_HI_BIT], control_word_one[`ADCFHP_THR_LO_BIT]});
    assign pulse_mode  = control_word_one[`ADCFHP_PULSE_BIT];
    assign active_high = control_word_one[`ADCFHP_POLARITY_BIT];
    assign sclk_rise   = sample_clock_in & ~sclk_prev;
    assign sclk_fall   = ~sample_clock_in & sclk_prev;
    // reserved code yields zero and never triggers
    assign reached = (threshold_count != {`ADCFHP_COUNT_W{1'b0}}) &
                     (fifo_fill >= threshold_count);

    always @* begin
        next_flag_state  = flag_state;
        next_flag_active = flag_active;
        next_reads_left  = reads_left;
        case (flag_state)
            ST_ARMED: begin
                // continuous pulses start on the conversion clock's rising edge
                if (reached && (!pulse_mode || !continuous_mode || sclk_rise)) begin
                    next_flag_active = 1'b1;
                    next_flag_state  = ST_DRAIN;
                    next_reads_left  = threshold_count;
                end
            end
            ST_DRAIN: begin
                if (pulse_mode) begin
                    if (!continuous_mode || sclk_fall) begin
                        next_flag_active = 1'b0;
                    end
                end else if (read_start) begin
                    // level clears on the first read
                    next_flag_active = 1'b0;
                end
                // no new pulse before those reads
                if (fifo_pop) begin
                    next_reads_left = reads_left - 5'h01;
                    if (reads_left == 5'h01) begin
                        next_flag_state = ST_ARMED;
                    end
                end
            end
            default: begin
                next_flag_state  = ST_ARMED;
                next_flag_active = 1'b0;
            end
        endcase
    end

    always @(posedge sys_clk) begin
        if (!nrst) begin
            flag_state      <= ST_ARMED;
            flag_active     <= 1'b0;
            reads_left      <= {`ADCFHP_COUNT_W{1'b0}};
            sclk_prev       <= 1'b0;
            fill_ready_flag <= 1'b0;
        end else begin
            flag_state      <= next_flag_state;
            flag_active     <= next_flag_active;
            reads_left      <= next_reads_left;
            sclk_prev       <= sample_clock_in;
            fill_ready_flag <= active_high ? next_flag_active : ~next_flag_active;
        end
    end

endmodule // adcfhp_port

// File: adcfhp_port_monitor.sv
`timescale 1ns/100ps
module adcfhp_port_monitor (
    input wire       sys_clk,
    input wire       nrst,
    input wire       chip_select_low_active,
    input wire       chip_select_high_active,
    input wire       read_strobe_n,
    input wire       write_strobe_n,
    input wire       control_word_select,
    input wire [9:0] bus_data_in,
    input wire       bus_data_oe_n,
    input wire       internal_read_pulse,
    input wire       internal_write_pulse,
    input wire [9:0] control_word_zero,
    input wire [9:0] control_word_one,
    input wire [4:0] fifo_fill,
    input wire       fill_ready_flag,
    input wire       continuous_mode,
    input wire       sample_clock_in,
    input wire       sample_valid
);
    wire dir_mode = control_word_one[6];
    wire picked   = !chip_select_low_active && chip_select_high_active;
    wire rd_act   = picked && write_strobe_n && (dir_mode || !read_strobe_n);
    wire wr_act   = picked && !write_strobe_n && (dir_mode || read_strobe_n);
    wire flag_on  = fill_ready_flag == control_word_one[5];

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    chk_read_drive: assert property (rd_act |=> !bus_data_oe_n && internal_read_pulse)
        else $error("read access did not drive the bus");
    chk_read_idle: assert property (!rd_act |=> bus_data_oe_n && !internal_read_pulse)
        else $error("bus driven outside a read access");
    chk_write_only: assert property (wr_act |=> internal_write_pulse && bus_data_oe_n)
        else $error("write access not seen or bus driven");
    chk_write_latch: assert property ($rose(wr_act) |=>
        ($past(control_word_select) ? control_word_one : control_word_zero) == $past(bus_data_in))
        else $error("control word not latched from bus");
    chk_pop_one: assert property ($rose(rd_act) && fifo_fill inside {[5'h01:5'h0F]}
        && !sample_valid && !$past(sample_valid) && !$past(sample_valid, 2)
        |=> fifo_fill == $past(fifo_fill) - 5'h01) else $error("read did not pop one word");
    chk_level_clear: assert property (!control_word_one[4] && flag_on && $rose(rd_act)
        && $stable(control_word_one) |=> !flag_on) else $error("level flag kept after read");
    chk_empty_quiet: assert property (fifo_fill == 5'h00 && $past(fifo_fill) == 5'h00
        && $stable(control_word_one) && $past(control_word_one) == $past(control_word_one, 2)
        |-> !flag_on) else $error("flag active with empty store");
    chk_pulse_short: assert property (control_word_one[4] && flag_on && $stable(control_word_one)
        && (!continuous_mode || !sample_clock_in) |=> !flag_on) else $error("pulse too long");
endmodule // adcfhp_port_monitor

bind adcfhp_port adcfhp_port_monitor adcfhp_port_monitor_inst (.sys_clk, .nrst,
    .chip_select_low_active, .chip_select_high_active, .read_strobe_n, .write_strobe_n,
    .control_word_select, .bus_data_in, .bus_data_oe_n, .internal_read_pulse,
    .internal_write_pulse, .control_word_zero, .control_word_one, .fifo_fill,
    .fill_ready_flag, .continuous_mode, .sample_clock_in, .sample_valid);

// File: adcfhp_host_model.sv
`timescale 1ns/100ps
module adcfhp_host_model (
    input  wire        sys_clk,
    output logic       chip_select_low_active,
    output logic       chip_select_high_active,
    output logic       read_strobe_n,
    output logic       write_strobe_n,
    output logic       control_word_select,
    output logic [9:0] bus_data_in
);
    logic dir_mode = 1'b0;
    initial begin
        chip_select_low_active = 1'b1;
        chip_select_high_active = 1'b0;
        read_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
        control_word_select = 1'b0;
        bus_data_in = 10'h000;
    end
    task automatic access(input logic rd, input logic sel, input logic [9:0] d);
        @(negedge sys_clk);
        control_word_select = sel;
        bus_data_in = d;
        write_strobe_n = rd;
        read_strobe_n = dir_mode | !rd;
        chip_select_high_active = 1'b1;
        chip_select_low_active = 1'b0;
        repeat (3) @(negedge sys_clk);
        chip_select_low_active = 1'b1;
        chip_select_high_active = 1'b0;
        read_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
        // Released data is not held, so a stale latch would show up.
        bus_data_in = ~d;
        @(negedge sys_clk);
    endtask
endmodule // adcfhp_host_model

// File: testbench.sv
`timescale 1ns/100ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin mismatches++; \
    $display("FAIL %s expected %0h seen %0h", n, e, a); end end
module testbench;
    logic        sys_clk = 1'b0;
    logic        nrst = 1'b0;
    logic [1:0]  active_channels = 2'h0;
    logic        continuous_mode = 1'b0;
    logic        sample_clock_in = 1'b0;
    logic        sample_valid = 1'b0;
    logic [11:0] sample_data = 12'h000;
    wire         chip_select_low_active, chip_select_high_active, read_strobe_n;
    wire         write_strobe_n, control_word_select, bus_data_oe_n, sample_ready;
    wire         internal_read_pulse, internal_write_pulse, fill_ready_flag;
    wire [9:0]   bus_data_in, control_word_zero, control_word_one;
    wire [11:0]  bus_data_out;
    wire [4:0]   fifo_fill;
    int          mismatches = 0;
    int          checks_done = 0;
    // expected fill levels, channel count major
    int          tl_tab[16] = '{1, 4, 8, 14, 2, 4, 8, 12, 3, 6, 9, 12, 4, 8, 12, 0};

    always #25 sys_clk = ~sys_clk;

    // free conversion clock
    // The conversion clock is one eighth of the system clock, so half a period is four cycles.
    always begin
        repeat (4) @(negedge sys_clk);
        sample_clock_in = ~sample_clock_in;
    end

    adcfhp_port adcfhp_port_inst (.sys_clk, .nrst, .chip_select_low_active,
        .chip_select_high_active, .read_strobe_n, .write_strobe_n, .control_word_select,
        .bus_data_in, .bus_data_out, .bus_data_oe_n, .active_channels, .continuous_mode,
        .sample_clock_in, .sample_valid, .sample_data, .sample_ready, .internal_read_pulse,
        .internal_write_pulse, .control_word_zero, .control_word_one, .fifo_fill,
        .fill_ready_flag);
    adcfhp_host_model adcfhp_host_model_inst (.sys_clk, .chip_select_low_active,
        .chip_select_high_active, .read_strobe_n, .write_strobe_n, .control_word_select,
        .bus_data_in);

    task automatic rd();
        adcfhp_host_model_inst.access(1'b1, 1'b0, 10'h000);
    endtask
    task automatic wr(input logic sel, input logic [9:0] d);
        adcfhp_host_model_inst.access(1'b0, sel, d);
    endtask
    task automatic push(input logic [11:0] w);
        int n;
        n = 0;
        sample_valid = 1'b1;
        sample_data = w;
        while (sample_ready !== 1'b1 && n < 50) begin
            n++;
            @(negedge sys_clk);
        end
        `CHK("sample ready", 1'b1, sample_ready)
        @(negedge sys_clk);
        sample_valid = 1'b0;
    endtask
    task automatic t_reset();
        `CHK("cw1", 10'h030, control_word_one)
        `CHK("cw0", 10'h000, control_word_zero)
        `CHK("flag", 1'b0, fill_ready_flag)
        `CHK("oe_n", 1'b1, bus_data_oe_n)
    endtask
    task automatic t_levels();
        int c, k, n, i;
        for (c = 0; c < 4; c++) begin
            for (k = 0; k < 4; k++) begin
                // reserved code skipped with four channels
                if (c == 3 && k == 3) continue;
                active_channels = c[1:0];
                wr(1'b1, 10'h020 | (k[9:0] << 2));
                n = 0;
                while (fill_ready_flag !== 1'b1 && n < 20) begin
                    n++;
                    push(12'h100 + n[11:0]);
                    repeat (3) @(negedge sys_clk);
                end
                `CHK("threshold", tl_tab[c * 4 + k], n)
                for (i = 1; i <= n; i++) begin
                    rd();
                    `CHK("word", 12'h100 + i[11:0], bus_data_out)
                end
            end
        end
    endtask
    task automatic t_buffer();
        int n, i;
        logic r;
        n = 0;
        active_channels = 2'h0;
        wr(1'b1, 10'h020);
        sample_valid = 1'b1;
        repeat (40) begin
            sample_data = 12'h200 + n[11:0];
            r = sample_ready;
            @(negedge sys_clk);
            if (r === 1'b1) n++;
        end
        sample_valid = 1'b0;
        `CHK("accepted", 18, n)
        `CHK("fill", 5'h10, fifo_fill)
        for (i = 0; i < 18; i++) begin
            rd();
            `CHK("drained", 12'h200 + i[11:0], bus_data_out)
        end
        `CHK("empty", 5'h00, fifo_fill)
    endtask
    task automatic t_direction();
        wr(1'b1, 10'h060);
        adcfhp_host_model_inst.dir_mode = 1'b1;
        wr(1'b0, 10'h155);
        `CHK("cw0", 10'h155, control_word_zero)
        push(12'h0AB);
        repeat (3) @(negedge sys_clk);
        rd();
        `CHK("dir word", 12'h0AB, bus_data_out)
        `CHK("cw1", 10'h060, control_word_one)
        wr(1'b1, 10'h020);
        adcfhp_host_model_inst.dir_mode = 1'b0;
    endtask
    task automatic t_pulse();
        int n;
        // Pulse type is only meant for continuous conversion, timed by the conversion clock.
        continuous_mode = 1'b1;
        wr(1'b1, 10'h010);
        for (int p = 0; p < 3; p++) begin
            if (p == 2) begin
                // Starting the read just after a conversion clock rise keeps the re-armed
                // pulse wholly inside the counting window below.
                @(posedge sample_clock_in);
                rd();
                `CHK("pulse word", 12'h3A0, bus_data_out)
            end else begin
                push(12'h3A0 + p[11:0]);
            end
            n = 0;
            repeat (16) begin
                @(negedge sys_clk);
                if (fill_ready_flag === 1'b0) n++;
            end
            if (p == 1) `CHK("pulse held", 0, n)
            else `CHK("pulse width", 4, n)
        end
    endtask
    task automatic results();
        $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        repeat (2) @(negedge sys_clk);
        nrst = 1'b1;
        @(negedge sys_clk);
        t_reset();
        t_levels();
        t_buffer();
        t_direction();
        t_pulse();
        results();
    end
    // The full run needs well under ten thousand cycles.
    initial begin
        #(50 * 30000);
        mismatches++;
        results();
    end
endmodule // testbench
